/* verilog/fsd_pkg.sv */
// Constants and types of the flash command sequence decoder
package fsd_pkg;
  localparam int AW = 26;
  localparam int SECT_LSB = 17;
  localparam int SW = AW - SECT_LSB;
  localparam logic [10:0] A_UNL1 = 11'h555;
  localparam logic [10:0] A_UNL2 = 11'h2AA;
  localparam logic [7:0] D_UNL1 = 8'hAA;
  localparam logic [7:0] D_UNL2 = 8'h55;
  localparam logic [7:0] C_ER_SETUP = 8'h80;
  localparam logic [7:0] C_CHIP = 8'h10;
  localparam logic [7:0] C_SECT = 8'h30;
  localparam logic [7:0] C_PROG = 8'hA0;
  localparam logic [7:0] C_BUF = 8'h25;
  localparam logic [7:0] C_BUF_CONF = 8'h29;
  localparam logic [7:0] C_RESET = 8'hF0;
  localparam logic [7:0] C_RESET_ALT = 8'hFF;
  localparam logic [7:0] C_BLANK = 8'h33;
  localparam logic [7:0] C_EVAL = 8'hD0;
  localparam logic [7:0] C_ESUSP = 8'hB0;
  localparam logic [7:0] C_ERES = 8'h30;
  localparam logic [7:0] C_PSUSP = 8'h51;
  localparam logic [7:0] C_PRES = 8'h50;
  localparam logic [7:0] C_ID = 8'h90;
  localparam logic [7:0] C_CFI = 8'h98;
  localparam logic [7:0] C_NV_ERASE = 8'hC8;
  localparam logic [7:0] C_NV_READ = 8'hC6;
  localparam logic [7:0] C_PROT = 8'h40;
  localparam logic [15:0] PCW_RESET = 16'hFFFF;
  localparam int PERS_LOCK_BIT = 1;
  localparam int PWD_LOCK_BIT = 2;
  localparam logic [1:0] PR_PCW = 2'h0;
  localparam logic [1:0] PR_STAT = 2'h1;
  localparam logic [1:0] PR_VOL = 2'h2;
  localparam logic [1:0] PR_PERS = 2'h3;
  localparam logic [15:0] ONES = 16'hFFFF;
  typedef enum logic [1:0] {MODE_ARRAY, MODE_ID, MODE_PROT} fsd_mode_t;
  typedef enum logic [3:0] {SQ_IDLE, SQ_UNL1, SQ_UNL2, SQ_ER_SETUP, SQ_ER_UNL1, SQ_ER_UNL2,
    SQ_PROG, SQ_BUF_WC, SQ_BUF_DATA, SQ_BUF_CONF, SQ_NV_READ, SQ_PROT_PROG} fsd_seq_t;
  typedef enum logic [3:0] {OP_NONE, OP_CHIP_ERASE, OP_SECT_ERASE, OP_WORD_PROG, OP_BUF_LOAD,
    OP_BUF_PROG, OP_BUF_ABORT, OP_BLANK, OP_EVAL, OP_ESUSP, OP_ERES, OP_PSUSP, OP_PRES,
    OP_NV_ERASE, OP_PROT_PROG} fsd_op_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [15:0] wdata;
  } fsd_bus_t;
  typedef struct packed {
    fsd_op_t op;
    logic [AW-1:0] addr;
    logic [SW-1:0] sector;
    logic [15:0] data;
  } fsd_cmd_t;
  typedef struct packed {
    fsd_seq_t seq;
    fsd_mode_t mode;
    logic [15:0] rdata;
    logic rdata_valid;
    fsd_cmd_t cmd;
    logic cmd_valid;
    logic first;
    logic er_busy;
    logic er_sector;
    logic esusp;
    logic pg_busy;
    logic psusp;
    logic buf_abort;
    logic [SW-1:0] buf_sect;
    logic [8:0] buf_cnt;
    logic [SW-1:0] erase_sect;
    logic [15:0] pcw;
  } fsd_state_t;
endpackage

/* verilog/fsd_decoder.sv */
// Command sequence decoder of the flash device
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
module fsd_decoder (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host word bus, one transfer per strobe
  input fsd_pkg::fsd_bus_t bus,
  input wire logic cs_n,
  // Data sources inside the device
  input wire logic [15:0] array_rdata,
  input wire logic [15:0] id_rdata,
  input wire logic [15:0] nvcfg_word,
  input wire logic sect_vol_open,
  input wire logic sect_pers_open,
  input wire logic op_done,
  // Read answer
  output logic [15:0] rdata,
  output logic rdata_valid,
  // Command towards the program and erase engine
  output fsd_pkg::fsd_cmd_t cmd,
  output logic cmd_valid,
  // Device state
  output fsd_pkg::fsd_mode_t mode,
  output logic erase_suspended,
  output logic prog_suspended,
  output logic buf_aborted
);
  import fsd_pkg::*;

  // Match one cycle on the low address and low data bits only
  function automatic logic hit(input logic [AW-1:0] a, input logic [15:0] d,
                               input logic [10:0] ea, input logic [7:0] ed);
    hit = (a[10:0] == ea) && (d[7:0] == ed);
  endfunction

  // Sector index, low-order bits dropped
  function automatic logic [SW-1:0] sect(input logic [AW-1:0] a);
    sect = a[AW-1:SECT_LSB];
  endfunction

  fsd_state_t s;
  fsd_state_t next_s;
  logic busy;
  logic a555;
  logic [7:0] dl;

  assign busy = s.er_busy | s.pg_busy;
  assign a555 = bus.addr[10:0] == A_UNL1;
  assign dl = bus.wdata[7:0];

  // ****************************************
  // Sequence decoding
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.cmd_valid = 1'b0;
    next_s.rdata_valid = 1'b0;
    next_s.cmd.addr = bus.addr;
    next_s.cmd.sector = sect(bus.addr);
    next_s.cmd.data = bus.wdata;
    if (cs_n) begin
      next_s.first = 1'b1;
    end
    // Engine finished: running op ends, suspended ones stay
    if (op_done) begin
      if (s.pg_busy && !s.psusp) begin
        next_s.pg_busy = 1'b0;
      end else if (s.er_busy && !s.esusp) begin
        next_s.er_busy = 1'b0;
        next_s.er_sector = 1'b0;
      end
    end
    if (bus.wr) begin
      next_s.seq = SQ_IDLE;
      case (s.seq)
        SQ_IDLE: begin
          if (hit(bus.addr, bus.wdata, A_UNL1, D_UNL1)) begin
            next_s.seq = SQ_UNL1;
          end else if (s.buf_abort) begin
            // Only the full abort reset leaves the abort state
            next_s.seq = SQ_IDLE;
          end else if (s.mode == MODE_PROT && dl == C_PROG) begin
            next_s.seq = SQ_PROT_PROG;
          end else if (dl == C_RESET || (dl == C_RESET_ALT && s.mode == MODE_ID)) begin
            next_s.mode = MODE_ARRAY;
          end else if (dl == C_CFI && a555) begin
            if (s.mode == MODE_ID || (s.mode == MODE_ARRAY && !busy)) begin
              next_s.mode = MODE_ID;
            end
          end else if (s.mode == MODE_ARRAY) begin
            if (dl == C_ESUSP && s.er_sector && !s.esusp) begin
              next_s.esusp = 1'b1;
              next_s.cmd.op = OP_ESUSP;
              next_s.cmd_valid = 1'b1;
            end else if (dl == C_ERES && s.esusp) begin
              next_s.esusp = 1'b0;
              next_s.cmd.op = OP_ERES;
              next_s.cmd_valid = 1'b1;
            end else if (dl == C_PSUSP && s.pg_busy && !s.psusp) begin
              next_s.psusp = 1'b1;
              next_s.cmd.op = OP_PSUSP;
              next_s.cmd_valid = 1'b1;
            end else if (dl == C_PRES && s.psusp) begin
              next_s.psusp = 1'b0;
              next_s.cmd.op = OP_PRES;
              next_s.cmd_valid = 1'b1;
            end else if ((dl == C_BLANK || dl == C_EVAL) && a555 && !busy) begin
              next_s.cmd.op = (dl == C_BLANK) ? OP_BLANK : OP_EVAL;
              next_s.cmd_valid = 1'b1;
              next_s.er_busy = 1'b1;
            end
          end
        end
        SQ_UNL1: begin
          if (hit(bus.addr, bus.wdata, A_UNL2, D_UNL2)) begin
            next_s.seq = SQ_UNL2;
          end
        end
        SQ_UNL2: begin
          if (dl == C_RESET && a555) begin
            // Abort reset also drops any open space
            next_s.buf_abort = 1'b0;
            next_s.mode = MODE_ARRAY;
          end else if (s.buf_abort) begin
            next_s.seq = SQ_IDLE;
          end else if (dl == C_ER_SETUP && a555 && !busy) begin
            next_s.seq = SQ_ER_SETUP;
          end else if (dl == C_PROG && a555 && (!busy || (s.esusp && !s.pg_busy))) begin
            next_s.seq = SQ_PROG;
          end else if (dl == C_BUF && (!busy || (s.esusp && !s.pg_busy))) begin
            next_s.seq = SQ_BUF_WC;
            next_s.buf_sect = sect(bus.addr);
          end else if (dl == C_ID && a555 && (!busy || s.esusp)) begin
            next_s.mode = MODE_ID;
          end else if (dl == C_NV_ERASE && a555 && !busy) begin
            next_s.cmd.op = OP_NV_ERASE;
            next_s.cmd_valid = 1'b1;
            next_s.er_busy = 1'b1;
          end else if (dl == C_NV_READ && a555) begin
            next_s.seq = SQ_NV_READ;
          end else if (dl == C_PROT && a555 && !busy) begin
            next_s.mode = MODE_PROT;
          end
        end
        SQ_ER_SETUP: begin
          if (hit(bus.addr, bus.wdata, A_UNL1, D_UNL1)) begin
            next_s.seq = SQ_ER_UNL1;
          end
        end
        SQ_ER_UNL1: begin
          if (hit(bus.addr, bus.wdata, A_UNL2, D_UNL2)) begin
            next_s.seq = SQ_ER_UNL2;
          end
        end
        SQ_ER_UNL2: begin
          if (dl == C_CHIP && a555) begin
            next_s.cmd.op = OP_CHIP_ERASE;
            next_s.cmd_valid = 1'b1;
            next_s.er_busy = 1'b1;
          end else if (dl == C_SECT) begin
            next_s.cmd.op = OP_SECT_ERASE;
            next_s.cmd_valid = 1'b1;
            next_s.er_busy = 1'b1;
            next_s.er_sector = 1'b1;
            next_s.erase_sect = sect(bus.addr);
          end
        end
        SQ_PROG: begin
          // The sector under a suspended erase cannot be programmed
          if (!(s.esusp && sect(bus.addr) == s.erase_sect)) begin
            next_s.cmd.op = OP_WORD_PROG;
            next_s.cmd_valid = 1'b1;
            next_s.pg_busy = 1'b1;
          end
        end
        SQ_BUF_WC: begin
          if (sect(bus.addr) == s.buf_sect && !(s.esusp && s.buf_sect == s.erase_sect)) begin
            next_s.buf_cnt = bus.wdata[8:0];
            next_s.seq = SQ_BUF_DATA;
          end else begin
            next_s.buf_abort = 1'b1;
            next_s.cmd.op = OP_BUF_ABORT;
            next_s.cmd_valid = 1'b1;
          end
        end
        SQ_BUF_DATA: begin
          next_s.cmd_valid = 1'b1;
          if (sect(bus.addr) != s.buf_sect) begin
            next_s.buf_abort = 1'b1;
            next_s.cmd.op = OP_BUF_ABORT;
          end else begin
            next_s.cmd.op = OP_BUF_LOAD;
            next_s.buf_cnt = s.buf_cnt - 9'h001;
            next_s.seq = (s.buf_cnt == 9'h000) ? SQ_BUF_CONF : SQ_BUF_DATA;
          end
        end
        SQ_BUF_CONF: begin
          next_s.cmd_valid = 1'b1;
          if (dl == C_BUF_CONF && sect(bus.addr) == s.buf_sect) begin
            next_s.cmd.op = OP_BUF_PROG;
            next_s.pg_busy = 1'b1;
          end else begin
            next_s.buf_abort = 1'b1;
            next_s.cmd.op = OP_BUF_ABORT;
          end
        end
        SQ_PROT_PROG: begin
          if (!bus.wdata[PERS_LOCK_BIT] && !bus.wdata[PWD_LOCK_BIT]) begin
            next_s.mode = MODE_ARRAY;
          end else begin
            next_s.pcw = s.pcw & bus.wdata;
            next_s.cmd.op = OP_PROT_PROG;
            next_s.cmd_valid = 1'b1;
          end
        end
        default: begin
          next_s.seq = SQ_IDLE;
        end
      endcase
    end else if (bus.rd) begin
      // A read breaks a half-written unlock or erase sequence
      if (s.seq inside {SQ_UNL1, SQ_UNL2, SQ_ER_SETUP, SQ_ER_UNL1, SQ_ER_UNL2}) begin
        next_s.seq = SQ_IDLE;
      end
      next_s.first = cs_n;
      if (s.seq == SQ_NV_READ) begin
        next_s.seq = SQ_IDLE;
        next_s.rdata = nvcfg_word;
        next_s.rdata_valid = s.first;
      end else if (s.mode == MODE_ID) begin
        next_s.rdata = id_rdata;
        next_s.rdata_valid = 1'b1;
      end else if (s.mode == MODE_PROT) begin
        // Register words: only the first word of a frame counts
        next_s.rdata_valid = s.first;
        case (bus.addr[1:0])
          PR_PCW: next_s.rdata = s.pcw;
          PR_STAT: next_s.rdata = {ONES[15:3], sect_pers_open, sect_vol_open,
                                   sect_pers_open & sect_vol_open};
          PR_VOL: next_s.rdata = {ONES[15:1], sect_vol_open};
          default: next_s.rdata = {ONES[15:1], sect_pers_open};
        endcase
      end else begin
        next_s.rdata = array_rdata;
        next_s.rdata_valid = 1'b1;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s <= '0;
      s.seq <= SQ_IDLE;
      s.mode <= MODE_ARRAY;
      s.first <= 1'b1;
      s.pcw <= PCW_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign rdata = s.rdata;
  assign rdata_valid = s.rdata_valid;
  assign cmd = s.cmd;
  assign cmd_valid = s.cmd_valid;
  assign mode = s.mode;
  assign erase_suspended = s.esusp;
  assign prog_suspended = s.psusp;
  assign buf_aborted = s.buf_abort;

  // ****************************************
  // Assertions and cover points
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  AST_ARRAY_READ: assert property (bus.rd && s.mode == MODE_ARRAY && s.seq != SQ_NV_READ
    |=> rdata_valid && rdata == $past(array_rdata)) else $error("array read lost");
  AST_NV_READ: assert property (bus.rd && s.seq == SQ_NV_READ && s.first
    |=> rdata_valid && rdata == $past(nvcfg_word) && s.seq == SQ_IDLE) else $error("config read bad");
  AST_ESUSP: assert property (cmd_valid && cmd.op == OP_ESUSP
    |-> $past(s.er_sector) && !$past(s.esusp) && s.esusp) else $error("erase suspend out of place");
  AST_RESUME: assert property (cmd_valid && (cmd.op == OP_ERES || cmd.op == OP_PRES)
    |-> (cmd.op == OP_ERES) ? $past(s.esusp) : $past(s.psusp)) else $error("resume without suspend");
  AST_OTP: assert property (1'b1 |=> (~$past(s.pcw) & s.pcw) == 16'h0000)
    else $error("protection bit erased");
  AST_LOCK_BOTH: assert property (bus.wr && s.seq == SQ_PROT_PROG && !bus.wdata[1] && !bus.wdata[2]
    |=> mode == MODE_ARRAY && !cmd_valid && s.pcw == $past(s.pcw)) else $error("dual lock not aborted");
  AST_CFI_GATE: assert property (bus.wr && s.seq == SQ_IDLE && dl == C_CFI && s.mode == MODE_PROT
    |=> mode == MODE_PROT) else $error("query entry taken");
  AST_FIRST: assert property (bus.rd && s.mode == MODE_PROT && !s.first
    |=> !rdata_valid) else $error("second register word valid");
  AST_STAT_FMT: assert property (bus.rd && s.mode == MODE_PROT && bus.addr[1:0] == PR_STAT
    |=> rdata[15:3] == 13'h1FFF) else $error("status upper bits");
  AST_ERASE_SEQ: assert property (bus.wr && s.seq == SQ_ER_UNL2 && dl == C_CHIP && a555
    |=> cmd_valid && cmd.op == OP_CHIP_ERASE ##1 !cmd_valid) else $error("chip erase lost");

  COV_SECT_ERASE: cover property (cmd_valid && cmd.op == OP_SECT_ERASE);
  COV_BUF_PROG: cover property (cmd_valid && cmd.op == OP_BUF_PROG);
  COV_SUSP_PROG: cover property (s.esusp && cmd_valid && cmd.op == OP_WORD_PROG);
  COV_ID_MODE: cover property (mode == MODE_ID);
endmodule // fsd_decoder

/* tb/fsd_host_model.sv */
// Host model that issues word bus cycles and frames to the decoder
`timescale 1ns/1ps
module fsd_host_model (
  // Clock
  input wire logic clk_sys,
  // Bus towards the device
  output fsd_pkg::fsd_bus_t bus,
  output logic cs_n,
  // Read answer
  input wire logic [15:0] rdata,
  input wire logic rdata_valid
);
  import fsd_pkg::*;
  logic [AW-1:0] last_a;
  logic [15:0] last_d;
  // Quiet bus and an open frame at time zero
  initial begin
    bus = '0;
    cs_n = 1'b0;
    last_a = '0;
    last_d = '0;
  end
  // One write strobe; values in hex, addresses in 16-bit words
  task automatic wr(input logic [AW-1:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    last_a = a;
    last_d = d;
  endtask
  // Released bus shows inverted leftovers so stale values cannot pass
  task automatic rel();
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b0, addr: ~last_a, wdata: ~last_d};
  endtask
  // One read strobe; the answer stands only in the following cycle
  task automatic rd(input logic [AW-1:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~last_d};
    last_a = a;
    rel();
    @(negedge clk_sys);
    d = rdata;
    v = rdata_valid;
  endtask
  // Two unlock cycles
  task automatic unlock();
    wr(26'h0000555, 16'h00AA);
    wr(26'h00002AA, 16'h0055);
  endtask
  // Leave any address space or status output
  task automatic exit_space(input logic [15:0] code);
    wr(26'h0000000, code);
  endtask
  // Full three-cycle sequence out of buffer abort
  task automatic abort_reset();
    unlock();
    wr(26'h0000555, 16'h00F0);
  endtask
  // Chip select high for one cycle re-arms the first word
  // Bus released first so a held write strobe is not taken twice
  task automatic new_frame();
    rel();
    cs_n <= 1'b1;
    @(posedge clk_sys);
    cs_n <= 1'b0;
  endtask
endmodule // fsd_host_model

/* tb/test_flash_command_sequence_decoder.sv */
// Self-checking bench of the flash command sequence decoder
`timescale 1ns/1ps
module test_flash_command_sequence_decoder;
  import fsd_pkg::*;
  // Sector bases: SA_A also sets bits 15..11, below the sector index at bit 17
  localparam logic [AW-1:0] SA_A = 26'h14AF800;
  localparam logic [AW-1:0] SA_B = 26'h0260000;
  logic clk_sys;
  logic resetn;
  fsd_bus_t bus;
  logic cs_n;
  logic [15:0] array_rdata, id_rdata, nvcfg_word, rdata, rv;
  logic sect_vol_open, sect_pers_open, op_done, rdata_valid, cmd_valid, vv;
  logic erase_suspended, prog_suspended, buf_aborted;
  fsd_cmd_t cmd;
  fsd_mode_t mode;
  int failures, total_checks, cycles;
  // Data sources answer in the same cycle, from the address
  assign array_rdata = bus.addr[15:0] ^ 16'h5A3C;
  assign id_rdata = bus.addr[15:0] + 16'h0100;
  fsd_decoder i_dut (.clk_sys(clk_sys), .resetn(resetn), .bus(bus), .cs_n(cs_n), .array_rdata(array_rdata),
    .id_rdata(id_rdata), .nvcfg_word(nvcfg_word), .sect_vol_open(sect_vol_open),
    .sect_pers_open(sect_pers_open), .op_done(op_done), .rdata(rdata), .rdata_valid(rdata_valid),
    .cmd(cmd), .cmd_valid(cmd_valid), .mode(mode), .erase_suspended(erase_suspended),
    .prog_suspended(prog_suspended), .buf_aborted(buf_aborted));
  fsd_host_model i_host (.clk_sys(clk_sys), .bus(bus), .cs_n(cs_n), .rdata(rdata), .rdata_valid(rdata_valid));
  // Compare tasks, one per kind of result
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_op(input fsd_op_t e, input logic [SW-1:0] s);
    total_checks++;
    if (cmd_valid !== 1'b1 || cmd.op !== e || cmd.sector !== s) begin
      failures++;
      $display("ERROR cmd expected %0d/%h seen %b/%0d/%h", e, s, cmd_valid, cmd.op, cmd.sector);
    end
  endtask
  // Release the bus and look in the cycle after the last write
  task automatic settle();
    i_host.rel();
    @(negedge clk_sys);
  endtask
  // One-cycle completion pulse from the engine
  task automatic finish_op();
    @(posedge clk_sys);
    op_done <= 1'b1;
    @(posedge clk_sys);
    op_done <= 1'b0;
  endtask
  task automatic t_reset();
    @(negedge clk_sys);
    chk("mode", 16'(MODE_ARRAY), 16'(mode));
    chk_bit("flags", 1'b0, erase_suspended | prog_suspended | buf_aborted | cmd_valid | rdata_valid);
    i_host.rd(26'h0001234, rv, vv);
    chk("array", 16'h1234 ^ 16'h5A3C, rv);
    chk_bit("valid", 1'b1, vv);
  endtask
  task automatic t_erase_suspend();
    i_host.wr(26'h3FFF555, 16'hC3AA);
    i_host.wr(26'h2AAAAAA, 16'h7E55);
    i_host.wr(26'h1555555, 16'hFF80);
    i_host.unlock();
    i_host.wr(SA_A + 26'h123, 16'h0030);
    settle();
    chk_op(OP_SECT_ERASE, 9'h0A5);
    i_host.wr(26'h0000ABC, 16'h00B0);
    settle();
    chk_op(OP_ESUSP, 9'h000);
    chk_bit("esusp", 1'b1, erase_suspended);
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h00A0);
    i_host.wr(SA_B + 26'h10, 16'hBEEF);
    settle();
    chk_op(OP_WORD_PROG, 9'h013);
    chk("prog data", 16'hBEEF, cmd.data);
    chk("prog addr", 16'h0010, cmd.addr[15:0]);
    finish_op();
    i_host.wr(26'h0000000, 16'h0050);
    settle();
    chk_bit("no pres", 1'b0, cmd_valid);
    i_host.wr(26'h0000000, 16'h0030);
    settle();
    chk_op(OP_ERES, 9'h000);
    chk_bit("esusp", 1'b0, erase_suspended);
    finish_op();
    i_host.wr(26'h0000000, 16'h00B0);
    settle();
    chk_bit("no esusp", 1'b0, cmd_valid);
  endtask
  task automatic t_prog_suspend();
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h00A0);
    i_host.wr(SA_A + 26'h40, 16'h1357);
    i_host.wr(26'h0000000, 16'h0051);
    settle();
    chk_op(OP_PSUSP, 9'h000);
    chk_bit("psusp", 1'b1, prog_suspended);
    i_host.wr(26'h0000000, 16'h0030);
    settle();
    chk_bit("no eres", 1'b0, cmd_valid);
    i_host.wr(26'h0000000, 16'h0050);
    settle();
    chk_op(OP_PRES, 9'h000);
    chk_bit("psusp", 1'b0, prog_suspended);
    finish_op();
  endtask
  task automatic t_chip_and_id();
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h0080);
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h0010);
    settle();
    chk_op(OP_CHIP_ERASE, 9'h000);
    i_host.wr(26'h0000555, 16'h0098);
    settle();
    chk("busy query", 16'(MODE_ARRAY), 16'(mode));
    finish_op();
    i_host.wr(SA_A + 26'h555, 16'h0098);
    i_host.rd(26'h0000027, rv, vv);
    chk("query mode", 16'(MODE_ID), 16'(mode));
    chk("id data", 16'h0127, rv);
    i_host.exit_space(16'h00F0);
    settle();
    chk("exit", 16'(MODE_ARRAY), 16'(mode));
    i_host.unlock();
    i_host.wr(SA_A + 26'h555, 16'h0090);
    i_host.rd(26'h0000027, rv, vv);
    chk("id data", 16'h0127, rv);
    i_host.exit_space(16'h00FF);
    settle();
    chk("exit", 16'(MODE_ARRAY), 16'(mode));
  endtask
  task automatic t_buffer();
    i_host.unlock();
    i_host.wr(SA_A, 16'h0025);
    i_host.wr(SA_A, 16'h0001);
    i_host.wr(SA_A + 26'h5, 16'h1111);
    i_host.wr(SA_A + 26'h6, 16'h2222);
    i_host.wr(SA_A, 16'h0029);
    settle();
    chk_op(OP_BUF_PROG, 9'h0A5);
    finish_op();
    i_host.unlock();
    i_host.wr(SA_A, 16'h0025);
    i_host.wr(SA_A, 16'h0000);
    i_host.wr(SA_B, 16'h3333);
    settle();
    chk_op(OP_BUF_ABORT, 9'h013);
    i_host.wr(26'h0000555, 16'h00F0);
    settle();
    chk_bit("aborted", 1'b1, buf_aborted);
    i_host.abort_reset();
    settle();
    chk_bit("aborted", 1'b0, buf_aborted);
  endtask
  task automatic t_single_ops();
    i_host.wr(SA_A + 26'h555, 16'h0033);
    settle();
    chk_op(OP_BLANK, 9'h0A5);
    finish_op();
    i_host.wr(SA_B + 26'h555, 16'h00D0);
    settle();
    chk_op(OP_EVAL, 9'h013);
    finish_op();
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h00C8);
    settle();
    chk_op(OP_NV_ERASE, 9'h000);
    finish_op();
  endtask
  task automatic t_config_read();
    i_host.new_frame();
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h00C6);
    i_host.rd(26'h0000000, rv, vv);
    chk("config", 16'hC3A5, rv);
    chk_bit("first", 1'b1, vv);
    // Same frame: a repeated config read is no longer the first word
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h00C6);
    i_host.rd(26'h0000000, rv, vv);
    chk_bit("second", 1'b0, vv);
  endtask
  // Each register read opens a new frame so only first words are judged
  task automatic prot_rd(input logic [AW-1:0] a, input logic [15:0] e, input string n);
    i_host.new_frame();
    i_host.rd(a, rv, vv);
    chk(n, e, rv);
  endtask
  task automatic t_protection();
    @(posedge clk_sys);
    sect_vol_open <= 1'b0;
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h0040);
    prot_rd(26'h0, 16'hFFFF, "pcw reset");
    // Second word of the same frame must not be flagged valid
    i_host.rd(26'h0, rv, vv);
    chk_bit("second word", 1'b0, vv);
    chk("prot mode", 16'(MODE_PROT), 16'(mode));
    prot_rd(SA_A + 26'h1, 16'hFFFC, "status");
    prot_rd(SA_A + 26'h2, 16'hFFFE, "vol lock");
    prot_rd(SA_A + 26'h3, 16'hFFFF, "pers lock");
    i_host.wr(26'h0000555, 16'h0098);
    settle();
    chk("prot query", 16'(MODE_PROT), 16'(mode));
    // One word per program command, lowest portion first
    i_host.wr(26'h0, 16'h00A0);
    i_host.wr(26'h0, 16'hFFF7);
    prot_rd(26'h0, 16'hFFF7, "pcw prog");
    i_host.wr(26'h0, 16'h00A0);
    i_host.wr(26'h0, 16'hFFFF);
    prot_rd(26'h0, 16'hFFF7, "pcw once");
    i_host.wr(26'h0, 16'h00A0);
    i_host.wr(26'h0, 16'hFFF9);
    settle();
    chk("both locks", 16'(MODE_ARRAY), 16'(mode));
    i_host.unlock();
    i_host.wr(26'h0000555, 16'h0040);
    prot_rd(26'h0, 16'hFFF7, "pcw kept");
    i_host.exit_space(16'h00F0);
  endtask
  // Verdict, printed once from here
  task automatic results();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Clock at 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      results();
    end
  end
  // Main sequence
  initial begin
    failures = 0;
    total_checks = 0;
    cycles = 0;
    resetn = 1'b0;
    nvcfg_word = 16'hC3A5;
    sect_vol_open = 1'b1;
    sect_pers_open = 1'b1;
    op_done = 1'b0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_erase_suspend();
    t_prog_suspend();
    t_chip_and_id();
    t_buffer();
    t_single_ops();
    t_config_read();
    t_protection();
    settle();
    results();
  end
endmodule // test_flash_command_sequence_decoder
